// ===== design/clm_state.sv
// clm_state: error history, product sum and result storage of the loop-math unit
// assumes the multiply datapath feeds products and sequencing strobes synchronous to mclk
// Operation
// - the second error-history register holds the previous loop error, high byte bits 15:8, low byte bits 7:0.
// - every product is added into a 35-bit sum, which moves to the result only when accumulation is complete.
// - the upper sum byte keeps only bits 2:0 as sum bits 34:32 and reads bits 7:3 as zero.
// - the sum is split into software read/write bytes for bits 31:24, 23:16, 15:8 and 7:0.
// - every implemented error-history and sum bit clears on power-on, brown-out and every other reset.
// - the error-history value is 17 bits, bit 16 alone in bit 0 of an upper byte whose bits 7:1 read zero.
// - the 36-bit result shows the final outcome once the calculation has completed.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module clm_state (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic soft_reset,
	input wire logic [clm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [clm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [clm_pkg::DATA_W-1:0] reg_rdata,
	input wire logic error_load,
	input wire logic [clm_pkg::ERR_W-1:0] error_value,
	input wire logic sum_clear,
	input wire logic product_valid,
	input wire logic [clm_pkg::SUM_W-1:0] product_value,
	input wire logic sum_done,
	output logic [clm_pkg::ERR_W-1:0] second_error_history,
	output logic [clm_pkg::SUM_W-1:0] product_sum,
	output logic [clm_pkg::RES_W-1:0] result_value
);
	import clm_pkg::*;

	typedef struct packed {
		logic [ERR_W-1:0] err2;
		logic [SUM_W-1:0] sum;
		logic [RES_W-1:0] res;
		logic [DATA_W-1:0] rdata;
	} clm_state_t;

	clm_state_t st_reg;
	clm_state_t st_next;

	// replace one byte lane of a wide value, keeping only the masked bits
	function automatic logic [RES_W-1:0] put_byte(input logic [RES_W-1:0] val, input int lane,
		input logic [DATA_W-1:0] data, input logic [DATA_W-1:0] mask);
		logic [RES_W-1:0] m;
		logic [RES_W-1:0] d;
		m = {{(RES_W-DATA_W){1'b0}}, mask} << (lane * DATA_W);
		d = {{(RES_W-DATA_W){1'b0}}, data & mask} << (lane * DATA_W);
		put_byte = (val & ~m) | d;
	endfunction

	// software write of one register byte; unimplemented bits never reach state
	function automatic clm_state_t sw_write(input clm_state_t st, input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] data);
		clm_state_t r;
		logic [RES_W-1:0] tmp;
		r = st;
		tmp = '0;
		case (addr)
			OFF_ERR2_UPPER: begin
				tmp = put_byte({{(RES_W-ERR_W){1'b0}}, st.err2}, 2, data, ERR2_UPPER_MASK);
				r.err2 = tmp[ERR_W-1:0];
			end
			OFF_ERR2_HIGH: begin
				r.err2[15:8] = data;
			end
			OFF_ERR2_LOW: begin
				r.err2[7:0] = data;
			end
			OFF_SUM_UPPER: begin
				tmp = put_byte({1'b0, st.sum}, 4, data, SUM_UPPER_MASK);
				r.sum = tmp[SUM_W-1:0];
			end
			OFF_SUM_HIGH_HIGH: begin
				r.sum[31:24] = data;
			end
			OFF_SUM_HIGH_LOW: begin
				r.sum[23:16] = data;
			end
			OFF_SUM_LOW_HIGH: begin
				r.sum[15:8] = data;
			end
			OFF_SUM_LOW_LOW: begin
				r.sum[7:0] = data;
			end
			OFF_RES_UPPER: begin
				r.res = put_byte(st.res, 4, data, RES_UPPER_MASK);
			end
			OFF_RES_HIGH_HIGH: begin
				r.res[31:24] = data;
			end
			OFF_RES_HIGH_LOW: begin
				r.res[23:16] = data;
			end
			OFF_RES_LOW_HIGH: begin
				r.res[15:8] = data;
			end
			OFF_RES_LOW_LOW: begin
				r.res[7:0] = data;
			end
			// unmapped offsets swallow the write
			default: begin
				r = st;
			end
		endcase
		return r;
	endfunction

	// read mux; unmapped offsets and unimplemented bits read as zero
	function automatic logic [DATA_W-1:0] sw_read(input clm_state_t st, input logic [ADDR_W-1:0] addr);
		logic [DATA_W-1:0] r;
		r = RDATA_RESET;
		case (addr)
			OFF_ERR2_UPPER: begin
				r = {7'h00, st.err2[16]};
			end
			OFF_ERR2_HIGH: begin
				r = st.err2[15:8];
			end
			OFF_ERR2_LOW: begin
				r = st.err2[7:0];
			end
			OFF_SUM_UPPER: begin
				r = {5'h00, st.sum[34:32]};
			end
			OFF_SUM_HIGH_HIGH: begin
				r = st.sum[31:24];
			end
			OFF_SUM_HIGH_LOW: begin
				r = st.sum[23:16];
			end
			OFF_SUM_LOW_HIGH: begin
				r = st.sum[15:8];
			end
			OFF_SUM_LOW_LOW: begin
				r = st.sum[7:0];
			end
			OFF_RES_UPPER: begin
				r = {4'h0, st.res[35:32]};
			end
			OFF_RES_HIGH_HIGH: begin
				r = st.res[31:24];
			end
			OFF_RES_HIGH_LOW: begin
				r = st.res[23:16];
			end
			OFF_RES_LOW_HIGH: begin
				r = st.res[15:8];
			end
			OFF_RES_LOW_LOW: begin
				r = st.res[7:0];
			end
			default: begin
				r = RDATA_RESET;
			end
		endcase
		return r;
	endfunction

	// products wrap modulo the sum width; the carry out is dropped on purpose
	function automatic logic [SUM_W-1:0] sum_add(input logic [SUM_W-1:0] sum, input logic [SUM_W-1:0] prod);
		logic [SUM_W:0] wide;
		wide = {1'b0, sum} + {1'b0, prod};
		return wide[SUM_W-1:0];
	endfunction

	// top result bit repeats the sign bit of the sum
	function automatic logic [RES_W-1:0] sum_to_result(input logic [SUM_W-1:0] sum);
		return {{(RES_W-SUM_W){sum[SUM_W-1]}}, sum};
	endfunction

	// one cycle of updates, later stages win
	always_comb begin
		st_next = st_reg;
		if (reg_wr) begin
			st_next = sw_write(st_reg, reg_addr, reg_wdata);
		end
		st_next.rdata = RDATA_RESET;
		// datapath updates come after software; a product in the same cycle adds onto a software-written sum byte
		if (error_load) begin
			st_next.err2 = error_value;
		end
		// a clear beside a product starts the new sum from that product
		if (sum_clear) begin
			st_next.sum = SUM_RESET;
		end
		if (product_valid) begin
			st_next.sum = sum_add(st_next.sum, product_value);
		end
		if (sum_done) begin
			st_next.res = sum_to_result(st_next.sum);
		end
		if (reg_rd) begin
			st_next.rdata = sw_read(st_reg, reg_addr);
		end
		// any non-power reset of the chip arrives here as a synchronous clear
		if (soft_reset) begin
			st_next.err2 = ERR2_RESET;
			st_next.sum = SUM_RESET;
			st_next.res = RES_RESET;
			st_next.rdata = RDATA_RESET;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_reg.err2 <= ERR2_RESET;
			st_reg.sum <= SUM_RESET;
			st_reg.res <= RES_RESET;
			st_reg.rdata <= RDATA_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign second_error_history = st_reg.err2;
	assign product_sum = st_reg.sum;
	assign result_value = st_reg.res;
endmodule // clm_state

// ===== design/clm_pkg.sv
// clm_pkg: register map, field layout and reset values for the loop-math state block
// assumes an 8-bit register port with a 4-bit byte address
package clm_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int ERR_W = 17;
	localparam int SUM_W = 35;
	localparam int RES_W = 36;

	localparam logic [ADDR_W-1:0] OFF_ERR2_UPPER = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_ERR2_HIGH = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_ERR2_LOW = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_SUM_UPPER = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_SUM_HIGH_HIGH = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_SUM_HIGH_LOW = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_SUM_LOW_HIGH = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_SUM_LOW_LOW = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_RES_UPPER = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_RES_HIGH_HIGH = 4'h9;
	localparam logic [ADDR_W-1:0] OFF_RES_HIGH_LOW = 4'ha;
	localparam logic [ADDR_W-1:0] OFF_RES_LOW_HIGH = 4'hb;
	localparam logic [ADDR_W-1:0] OFF_RES_LOW_LOW = 4'hc;

	// implemented-bit masks of the upper bytes
	localparam logic [DATA_W-1:0] ERR2_UPPER_MASK = 8'h01;
	localparam logic [DATA_W-1:0] SUM_UPPER_MASK = 8'h07;
	localparam logic [DATA_W-1:0] RES_UPPER_MASK = 8'h0f;

	localparam logic [ERR_W-1:0] ERR2_RESET = 17'h00000;
	localparam logic [SUM_W-1:0] SUM_RESET = 35'h000000000;
	localparam logic [RES_W-1:0] RES_RESET = 36'h000000000;
	localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
endpackage

// ===== sim/clm_state_monitor.sv
// clm_state_monitor: port timing checks of clm_state
// assumes one mclk domain, nrst async active low
`timescale 1ns/1ps
module clm_state_monitor import clm_pkg::*; (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic soft_reset,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic error_load,
	input wire logic [ERR_W-1:0] error_value,
	input wire logic sum_clear,
	input wire logic product_valid,
	input wire logic [SUM_W-1:0] product_value,
	input wire logic sum_done,
	input wire logic [ERR_W-1:0] second_error_history,
	input wire logic [SUM_W-1:0] product_sum,
	input wire logic [RES_W-1:0] result_value
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_wr(logic [3:0] a); reg_wr && reg_addr == a && !soft_reset; endsequence
	sequence s_rd(logic [3:0] a); reg_rd && reg_addr == a && !soft_reset && !sum_clear && !product_valid; endsequence
	a_err_load: assert property (error_load && !soft_reset |=> second_error_history == $past(error_value))
		else $error("history load wrong");
	a_sum_add: assert property (product_valid && !sum_clear && !soft_reset && !reg_wr |=>
		product_sum == 35'($past(product_sum) + $past(product_value))) else $error("sum add wrong");
	a_sum_clear: assert property (sum_clear && !product_valid && !soft_reset |=> product_sum == 35'h0)
		else $error("sum clear wrong");
	a_res_hold: assert property (!sum_done && !soft_reset && !reg_wr |=> $stable(result_value))
		else $error("result moved early");
	a_res_copy: assert property (sum_done && !soft_reset |=> result_value == {product_sum[34], product_sum})
		else $error("result copy wrong");
	a_sum_upper: assert property (s_rd(OFF_SUM_UPPER) |=> reg_rdata == {5'h00, $past(product_sum[34:32])})
		else $error("sum upper read wrong");
	a_err_upper: assert property (s_rd(OFF_ERR2_UPPER) |=> reg_rdata == {7'h00, $past(second_error_history[16])})
		else $error("history upper read wrong");
	a_wr_low: assert property (s_wr(OFF_SUM_LOW_LOW) ##0 !sum_clear && !product_valid |=>
		product_sum[7:0] == $past(reg_wdata)) else $error("sum byte write wrong");
	a_wr_upper: assert property (s_wr(OFF_ERR2_UPPER) ##0 !error_load |=>
		second_error_history == {$past(reg_wdata[0]), $past(second_error_history[15:0])}) else $error("upper write wrong");
	a_soft_clr: assert property (soft_reset |=> {second_error_history, product_sum, result_value, reg_rdata} == 96'h0)
		else $error("soft clear missed");
endmodule // clm_state_monitor
bind clm_state clm_state_monitor u_clm_state_monitor(
	.mclk(mclk),
	.nrst(nrst),
	.soft_reset(soft_reset),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.error_load(error_load),
	.error_value(error_value),
	.sum_clear(sum_clear),
	.product_valid(product_valid),
	.product_value(product_value),
	.sum_done(sum_done),
	.second_error_history(second_error_history),
	.product_sum(product_sum),
	.result_value(result_value)
);

// ===== sim/tb_clm_state.sv
// tb_clm_state: register map, load, sum and clear tests against a bench model
// assumes clm_state alone, bus driven after rising edges
`timescale 1ns/1ps
module tb_clm_state;
	import clm_pkg::*;
	logic mclk = 0, nrst = 0, soft_reset = 0, reg_wr = 0, reg_rd = 0, error_load = 0, sum_clear = 0, product_valid = 0, sum_done = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic [16:0] error_value = 0, second_error_history, err_m = 0;
	logic [34:0] product_value = 0, product_sum, sum_m = 0, p;
	logic [35:0] result_value, res_m = 0;
	int errors = 0, cmp_count = 0, cyc = 0, seed = 4520, i;
	always #2 mclk = ~mclk;
	clm_state u_clm_state(.mclk, .nrst, .soft_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .error_load,
		.error_value, .sum_clear, .product_valid, .product_value, .sum_done, .second_error_history, .product_sum, .result_value);
	// model image, byte 0 at the top; unimplemented bits stay zero
	function logic [103:0] img();
		return {7'h0, err_m, 5'h0, sum_m, 4'h0, res_m};
	endfunction
	task chk(string n, logic [35:0] e, logic [35:0] s);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(logic [3:0] a, logic [7:0] d);
		logic [103:0] v;
		v = img();
		if (a < 4'hd) v[8*(12-a) +: 8] = d;
		{err_m, sum_m, res_m} = {v[96:80], v[74:40], v[35:0]};
		@(posedge mclk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge mclk);
		reg_wr <= 0;
	endtask
	task rd_all(string s);
		logic [103:0] v;
		for (int j = 0; j < 16; j++) begin
			v = img();
			@(posedge mclk);
			{reg_rd, reg_addr} <= {1'b1, 4'(j)};
			@(posedge mclk);
			reg_rd <= 0;
			#1 chk("rdata", (j < 13) ? v[8*(12-j) +: 8] : 0, reg_rdata);
			// read data stand one cycle only
			@(posedge mclk);
			#1 chk("rdata idle", 0, reg_rdata);
		end
		$display("test %s done", s);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// bounded run, a hang counts as a mismatch
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			finish_test;
		end
	end
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1;
		rd_all("reset");
		for (i = 0; i < 16; i++) wr(4'(i), 8'($random(seed)));
		rd_all("write");
		@(posedge mclk);
		err_m = 17'($random(seed));
		{error_load, error_value} <= {1'b1, err_m};
		@(posedge mclk);
		error_load <= 0;
		#1 chk("history", err_m, second_error_history);
		@(posedge mclk);
		sum_clear <= 1;
		sum_m = 0;
		for (i = 0; i < 4; i++) begin
			p = 35'({$random(seed), $random(seed)});
			@(posedge mclk);
			{sum_clear, product_valid, product_value, sum_done} <= {i == 0, 1'b1, p, i == 3};
			sum_m = sum_m + p;
		end
		res_m = {sum_m[34], sum_m};
		@(posedge mclk);
		{product_valid, sum_done} <= 2'b00;
		#1 chk("sum", sum_m, product_sum);
		chk("result", res_m, result_value);
		rd_all("sum");
		@(posedge mclk);
		{soft_reset, error_load} <= 2'b11;
		{err_m, sum_m, res_m} = 0;
		@(posedge mclk);
		{soft_reset, error_load} <= 2'b00;
		rd_all("soft reset");
		// reload nonzero state, then pull the asynchronous reset mid-run
		for (i = 0; i < 13; i++) wr(4'(i), 8'($random(seed)));
		@(posedge mclk);
		nrst <= 0;
		{err_m, sum_m, res_m} = 0;
		repeat (2) @(posedge mclk);
		nrst <= 1;
		rd_all("power reset");
		finish_test;
	end
endmodule // tb_clm_state
